// ### rtl/ssp_consts.vh
/*
  Constants for the synchronous serial shift port: control field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from the design files under rtl/.
*/
// What this block does
// - Master data write starts eight-bit shift out
// - Master halts after byte, sets done flag
// - Last received byte held in receive buffer
// - Slave idle, data-out undriven while select high
// - Slave loaded data waits for select low
// - Slave sets done flag after full byte
// - Read received byte before next completes
// - Port forces pin directions while enabled
// - Data master-to-slave on MOSI, back on MISO
// - Port dead unless power gate bit is zero
// - Seven master rates including divide by two
// - Selectable LSB-first or MSB-first order
// - Collision flag on write during shifting
// - Completed transfer wakes from idle sleep
// - Slave select high resets partial receive
// - Select low as master forces slave mode
// - Polarity sets idle level, phase sample edge
// - Rate bits and double bit pick divisor
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ==========================================================
// Control field positions
`define SSP_CTL_RATE0    0
`define SSP_CTL_RATE1    1
`define SSP_CTL_PHASE    2
`define SSP_CTL_POL      3
`define SSP_CTL_MASTER   4
`define SSP_CTL_ORDER    5
`define SSP_CTL_ENABLE   6
`define SSP_CTL_IRQEN    7

// ==========================================================
// Reset values
`define SSP_CTL_RST      8'h00
`define SSP_DATA_RST     8'h00

// ==========================================================
// Timing
`define SSP_BITS         4'h8
`define SSP_SCK_MIN_SYS  2
`define SSP_DIV_WIDTH    7

`endif

// ### rtl/ssp_rx_buf.v
/*
  Receive buffer word store: holds the most recently completed byte.
  Assumes one clock and the synchronised active-low reset from the top.
*/
`timescale 1ns/10ps
module ssp_rx_buf #(
  parameter WIDTH = 8
) (
  input  wire             i_clk_sys,
  input  wire             i_rst_n,
  input  wire             i_wr,
  input  wire [WIDTH-1:0] i_wdata,
  output reg  [WIDTH-1:0] o_rdata
);
  // ==========================================================
  // Storage, read data straight from the register
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      o_rdata <= {WIDTH{1'b0}};
    else if (i_wr)
      o_rdata <= i_wdata;
  end
endmodule

// ### rtl/ssp_port.v
/*
  Synchronous serial shift port, master or slave, eight-bit full duplex.
  Control bits arrive as plain ports; data writes and reads are strobes.
  Assumes i_clk_sys at 20 MHz and inputs synchronous to it.
*/
`timescale 1ns/10ps
`include "ssp_consts.vh"
module ssp_port #(
  parameter NBITS = 8
) (
  input  wire       i_clk_sys,
  input  wire       i_rstn,
  input  wire       i_port_power_gate_bit,
  input  wire [7:0] i_port_control_reg,
  input  wire       i_double_rate_bit,
  input  wire       i_ss_is_input,
  input  wire       i_wr_data,
  input  wire [7:0] i_wdata,
  input  wire       i_rd_status,
  input  wire       i_rd_data,
  input  wire       i_mosi,
  input  wire       i_miso,
  input  wire       i_sck,
  input  wire       i_ss_n,
  output reg        o_mosi,
  output reg        o_mosi_oe,
  output reg        o_miso,
  output reg        o_miso_oe,
  output reg        o_sck,
  output reg        o_sck_oe,
  output reg  [7:0] o_rdata,
  output reg        o_xfer_done_flag,
  output reg        o_write_coll_flag,
  output reg        o_irq,
  output reg        o_wake,
  output reg        o_master_select_bit,
  output reg        o_busy
);
  // ==========================================================
  // Reset release through two flops
  reg rst_s1_ff, rst_n_ff;
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // State codes, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_LEAD = 3'b010;
  localparam ST_TRAIL = 3'b100;

  // Divisor half-period from rate bits
  function [`SSP_DIV_WIDTH-1:0] half_div;
    input [1:0] rate;
    input       dbl;
    reg   [`SSP_DIV_WIDTH-1:0] h;
    begin
      h = 7'h01;
      case (rate)
        2'b00: h = 7'h02;
        2'b01: h = 7'h08;
        2'b10: h = 7'h20;
        2'b11: h = 7'h40;
        default: h = 7'h02;
      endcase
      half_div = dbl ? (h >> 1) : h;
    end
  endfunction

  // Next bit to send from a byte, by order
  function tx_bit;
    input [7:0] b;
    input       lsb_first;
    begin
      tx_bit = lsb_first ? b[0] : b[7];
    end
  endfunction

  // ==========================================================
  // Control decode
  wire active   = ~i_port_power_gate_bit & i_port_control_reg[`SSP_CTL_ENABLE];
  wire clock_idle_polarity     = i_port_control_reg[`SSP_CTL_POL];
  wire clock_sample_phase     = i_port_control_reg[`SSP_CTL_PHASE];
  wire lsb1st   = i_port_control_reg[`SSP_CTL_ORDER];
  wire irq_en   = i_port_control_reg[`SSP_CTL_IRQEN];
  wire master_select_bit_req = i_port_control_reg[`SSP_CTL_MASTER];

  reg [2:0] state_ff, nxt_state;
  reg [7:0] shreg_ff, nxt_shreg;
  reg [3:0] cnt_ff, nxt_cnt;
  reg [6:0] div_ff, nxt_div;
  reg       master_select_bit_ff, nxt_master_select_bit;
  reg       master_select_bit_req_d_ff;
  reg       sck_ff, nxt_sck;
  reg       sck_s_ff, sck_p_ff;
  reg [1:0] sck_v_ff;
  reg       rx_bit_ff, nxt_rx_bit;
  reg       done_ff, nxt_done;
  reg       coll_ff, nxt_coll;
  reg       rx_wr;
  reg [7:0] rx_word;
  wire [7:0] rx_q;

  // Master bit writes set it; select forcing clears it
  wire master_select_bit_rise = master_select_bit_req & ~master_select_bit_req_d_ff;
  wire is_master_select_bit   = master_select_bit_ff;
  wire sel_n     = i_ss_n;
  wire busy      = (state_ff != ST_IDLE);
  wire rx_in     = is_master_select_bit ? i_miso : i_mosi;

  // Slave clock edges, sampled; the source phases are kept wide
  // Edges count only once both sample flops hold real pin values
  wire s_rise   = sck_s_ff & ~sck_p_ff & sck_v_ff[1];
  wire s_fall   = ~sck_s_ff & sck_p_ff & sck_v_ff[1];
  wire s_lead   = clock_idle_polarity ? s_fall : s_rise;
  wire s_trail  = clock_idle_polarity ? s_rise : s_fall;
  wire s_sample = clock_sample_phase ? s_trail : s_lead;
  wire s_setup  = clock_sample_phase ? s_lead : s_trail;

  // ==========================================================
  // Next-state logic
  always @* begin
    nxt_state  = state_ff;
    nxt_shreg  = shreg_ff;
    nxt_cnt    = cnt_ff;
    nxt_div    = div_ff;
    nxt_master_select_bit   = master_select_bit_ff;
    nxt_sck    = sck_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_done   = done_ff;
    nxt_coll   = coll_ff;
    rx_wr      = 1'b0;
    rx_word    = lsb1st ? {rx_bit_ff, shreg_ff[7:1]} : {shreg_ff[6:0], rx_bit_ff};
    // Software read of data alone clears flags; the status read strobe is unused
    if (i_rd_data) begin
      nxt_done = 1'b0;
      nxt_coll = 1'b0;
    end
    if (master_select_bit_rise)
      nxt_master_select_bit = 1'b1;
    if (!master_select_bit_req)
      nxt_master_select_bit = 1'b0;
    // Write during a shift only flags; the shift path never takes it
    if (active && i_wr_data && busy)
      nxt_coll = 1'b1;
    if (!active) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = 4'h0;
      nxt_sck   = clock_idle_polarity;
      if (i_wr_data)
        nxt_shreg = i_wdata;
    end else if (is_master_select_bit && i_ss_is_input && !sel_n) begin
      nxt_master_select_bit  = 1'b0;
      nxt_done  = 1'b1;
      nxt_state = ST_IDLE;
      nxt_cnt   = 4'h0;
      nxt_sck   = clock_idle_polarity;
    end else if (is_master_select_bit) begin
      case (state_ff)
        ST_IDLE: begin
          nxt_sck = clock_idle_polarity;
          if (i_wr_data) begin
            nxt_shreg = i_wdata;
            nxt_state = ST_LEAD;
            nxt_cnt   = 4'h0;
            nxt_div   = half_div(i_port_control_reg[1:0], i_double_rate_bit) - 7'h01;
          end
        end
        ST_LEAD, ST_TRAIL: begin
          if (div_ff != 7'h00) begin
            nxt_div = div_ff - 7'h01;
          end else begin
            nxt_div = half_div(i_port_control_reg[1:0], i_double_rate_bit) - 7'h01;
            nxt_sck = ~sck_ff;
            if (state_ff == ST_LEAD) begin
              nxt_state = ST_TRAIL;
              if (!clock_sample_phase)
                nxt_rx_bit = rx_in;
              else if (cnt_ff != 4'h0)
                nxt_shreg = lsb1st ? {rx_bit_ff, shreg_ff[7:1]}
                                   : {shreg_ff[6:0], rx_bit_ff};
            end else begin
              if (clock_sample_phase)
                nxt_rx_bit = rx_in;
              else
                nxt_shreg = rx_word;
              nxt_cnt = cnt_ff + 4'h1;
              if (cnt_ff == `SSP_BITS - 4'h1) begin
                nxt_state = ST_IDLE;
                if (clock_sample_phase)
                  rx_word = lsb1st ? {rx_in, shreg_ff[7:1]} : {shreg_ff[6:0], rx_in};
                nxt_shreg = rx_word;
                rx_wr     = 1'b1;
                nxt_done  = 1'b1;
                nxt_sck   = clock_idle_polarity;
              end else begin
                nxt_state = ST_LEAD;
              end
            end
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end else begin
      // Slave: parked while select high
      if (sel_n) begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 4'h0;
        if (i_wr_data)
          nxt_shreg = i_wdata;
      end else begin
        if (i_wr_data && !busy)
          nxt_shreg = i_wdata;
        if (s_sample) begin
          nxt_state  = ST_LEAD;
          nxt_rx_bit = i_mosi;
        end
        if (s_setup && cnt_ff != 4'h0 && busy) begin
          nxt_shreg = rx_word;
          if (cnt_ff == `SSP_BITS) begin
            nxt_cnt   = 4'h0;
            nxt_state = ST_IDLE;
          end
        end
        if (s_sample) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == `SSP_BITS - 4'h1) begin
            rx_wr     = 1'b1;
            rx_word   = lsb1st ? {i_mosi, shreg_ff[7:1]} : {shreg_ff[6:0], i_mosi};
            nxt_shreg = rx_word;
            nxt_done  = 1'b1;
            nxt_state = ST_IDLE;
            nxt_cnt   = 4'h0;
          end
        end
      end
    end
  end

  // ==========================================================
  // State registers
  always @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff      <= ST_IDLE;
      shreg_ff      <= `SSP_DATA_RST;
      cnt_ff        <= 4'h0;
      div_ff        <= 7'h00;
      master_select_bit_ff       <= 1'b0;
      master_select_bit_req_d_ff <= 1'b0;
      sck_ff        <= 1'b0;
      sck_s_ff      <= 1'b0;
      sck_p_ff      <= 1'b0;
      sck_v_ff      <= 2'b00;
      rx_bit_ff     <= 1'b0;
      done_ff       <= 1'b0;
      coll_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      shreg_ff      <= nxt_shreg;
      cnt_ff        <= nxt_cnt;
      div_ff        <= nxt_div;
      master_select_bit_ff       <= nxt_master_select_bit;
      master_select_bit_req_d_ff <= master_select_bit_req;
      sck_ff        <= nxt_sck;
      sck_s_ff      <= i_sck;
      sck_p_ff      <= sck_s_ff;
      sck_v_ff      <= {sck_v_ff[0], 1'b1};
      rx_bit_ff     <= nxt_rx_bit;
      done_ff       <= nxt_done;
      coll_ff       <= nxt_coll;
    end
  end

  // Receive buffer, second stage behind the shift register
  ssp_rx_buf #(.WIDTH(8)) u_rx_buf (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_ff),
    .i_wr      (rx_wr),
    .i_wdata   (rx_word),
    .o_rdata   (rx_q)
  );

  // ==========================================================
  // Registered outputs and pin directions
  always @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_mosi              <= 1'b0;
      o_mosi_oe           <= 1'b0;
      o_miso              <= 1'b0;
      o_miso_oe           <= 1'b0;
      o_sck               <= 1'b0;
      o_sck_oe            <= 1'b0;
      o_rdata             <= 8'h00;
      o_xfer_done_flag    <= 1'b0;
      o_write_coll_flag   <= 1'b0;
      o_irq               <= 1'b0;
      o_wake              <= 1'b0;
      o_master_select_bit <= 1'b0;
      o_busy              <= 1'b0;
    end else begin
      // Data out held through the last sample edge in phase-1 mode
      o_mosi              <= (rx_wr & clock_sample_phase & is_master_select_bit) ? o_mosi : tx_bit(nxt_shreg, lsb1st);
      o_miso              <= tx_bit(nxt_shreg, lsb1st);
      o_mosi_oe           <= active & nxt_master_select_bit;
      o_sck_oe            <= active & nxt_master_select_bit;
      o_miso_oe           <= active & ~nxt_master_select_bit & ~sel_n;
      o_sck               <= nxt_sck;
      o_rdata             <= rx_wr ? rx_word : rx_q;
      o_xfer_done_flag    <= nxt_done;
      o_write_coll_flag   <= nxt_coll;
      o_irq               <= nxt_done & irq_en;
      o_wake              <= nxt_done & ~done_ff;
      o_master_select_bit <= nxt_master_select_bit;
      o_busy              <= (nxt_state != ST_IDLE);
    end
  end
endmodule

// ### test/ssp_port_asserts.sv
/*
  Port checker for the serial shift port, bound to ssp_port.
  Assumes one clock and the active-low reset seen at the ports.
*/
`timescale 1ns/10ps
module ssp_port_asserts (
  input wire       i_clk_sys,
  input wire       i_rstn,
  input wire       i_port_power_gate_bit,
  input wire [7:0] i_port_control_reg,
  input wire       i_ss_is_input,
  input wire       i_wr_data,
  input wire       i_ss_n,
  input wire       o_miso_oe,
  input wire       o_sck,
  input wire       o_xfer_done_flag,
  input wire       o_write_coll_flag,
  input wire       o_wake,
  input wire       o_master_select_bit,
  input wire       o_busy
);
  // ==========================================
  // Port relations
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire act = i_port_control_reg[6] && !i_port_power_gate_bit;
  a_start_busy: assert property (act && o_master_select_bit && i_wr_data && !o_busy |=> o_busy)
    else $error("write did not start shifting");
  a_done_at_end: assert property ($fell(o_busy) && o_master_select_bit |-> o_xfer_done_flag)
    else $error("byte end without done flag");
  a_wake_pulse: assert property ($rose(o_xfer_done_flag) |-> ##[0:1] (o_wake ##1 !o_wake))
    else $error("wake pulse missing or long");
  a_coll_set: assert property (act && o_busy && i_wr_data |-> ##[1:2] o_write_coll_flag)
    else $error("collision flag not set");
  a_gate_idle: assert property (i_port_power_gate_bit [*3] |-> !o_busy)
    else $error("gated port is shifting");
  a_slave_tri: assert property ((!o_master_select_bit && i_ss_n) [*3] |-> !o_miso_oe)
    else $error("deselected slave drives data out");
  a_sck_idle: assert property ((o_master_select_bit && !o_busy && $stable(i_port_control_reg)) [*3]
    |-> o_sck == i_port_control_reg[3])
    else $error("idle clock level wrong");
  a_fault_slave: assert property (act && o_master_select_bit && i_ss_is_input && !i_ss_n
    |-> ##[1:3] (!o_master_select_bit && o_xfer_done_flag))
    else $error("select low did not force slave");
  c_done: cover property ($rose(o_xfer_done_flag));
  c_coll: cover property ($rose(o_write_coll_flag));
  c_fault: cover property ($fell(o_master_select_bit));
endmodule
bind ssp_port ssp_port_asserts u_chk (.i_clk_sys, .i_rstn, .i_port_power_gate_bit,
  .i_port_control_reg, .i_ss_is_input, .i_wr_data, .i_ss_n, .o_miso_oe, .o_sck,
  .o_xfer_done_flag, .o_write_coll_flag, .o_wake, .o_master_select_bit, .o_busy);

// ### test/ssp_peer_model.sv
/*
  Far-side slave model, any of the four clock modes, either bit order.
  Assumes the master drives clock and select; data-in is the master's out.
*/
`timescale 1ns/10ps
module ssp_peer_model (
  input  wire       i_sck,
  input  wire       i_ss_n,
  input  wire       i_mosi,
  input  wire       i_lsb,
  input  wire       i_clock_idle_polarity,
  input  wire       i_clock_sample_phase,
  input  wire [7:0] i_tx,
  output reg        o_miso = 1'b0,
  output reg  [7:0] o_rx = 8'h00
);
  reg [7:0] sh_ff = 8'h00;
  // ==========================================
  // Preload and show first bit on select
  always @(negedge i_ss_n) begin
    sh_ff = i_tx;
    o_miso = i_lsb ? i_tx[0] : i_tx[7];
  end
  // Sample edge shifts in, setup edge shows the next bit
  always @(i_sck) if (!i_ss_n) begin
    if ((i_sck != i_clock_idle_polarity) != i_clock_sample_phase) begin
      o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      sh_ff = i_lsb ? {1'b0, sh_ff[7:1]} : {sh_ff[6:0], 1'b0};
    end else begin
      o_miso = i_lsb ? sh_ff[0] : sh_ff[7];
    end
  end
  // Released line shows the inverse
  always @(posedge i_ss_n) o_miso = ~o_miso;
endmodule

// ### test/tb_sync_serial_shift_port.sv
/*
  Self-checking bench for the serial shift port as slave and master.
  Assumes ssp_port, its checker and the peer model are compiled first.
*/
`timescale 1ns/10ps
module tb_sync_serial_shift_port;
  reg        clk = 0, rstn = 0, gate = 0, ssin = 0, wr = 0, rd = 0, dbl = 0;
  reg        sck_drv = 0, mosi_drv = 0, ss_n = 1;
  reg  [7:0] ctl = 8'h00, wdata = 8'h00, peer_tx = 8'h00, got = 8'h00;
  integer    num_errors = 0, cmp_count = 0, wakes = 0, i;
  wire       mosi, mosi_oe, miso, miso_oe, sck_o, sck_oe, done, coll, irq, wake, mst, busy;
  wire       peer_miso;
  wire [7:0] rdata, peer_rx;
  wire       sck = sck_oe ? sck_o : sck_drv;
  wire       mosi_w = mosi_oe ? mosi : mosi_drv;
  // ==========================================
  // Design, peer and clock
  ssp_port dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_port_power_gate_bit(gate),
    .i_port_control_reg(ctl), .i_double_rate_bit(dbl), .i_ss_is_input(ssin), .i_wr_data(wr),
    .i_wdata(wdata), .i_rd_status(1'b0), .i_rd_data(rd), .i_mosi(mosi_w), .i_miso(peer_miso),
    .i_sck(sck), .i_ss_n(ss_n), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .o_miso(miso),
    .o_miso_oe(miso_oe), .o_sck(sck_o), .o_sck_oe(sck_oe), .o_rdata(rdata),
    .o_xfer_done_flag(done), .o_write_coll_flag(coll), .o_irq(irq), .o_wake(wake),
    .o_master_select_bit(mst), .o_busy(busy));
  ssp_peer_model peer_u (.i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi_w), .i_lsb(ctl[5]),
    .i_clock_idle_polarity(ctl[3]), .i_clock_sample_phase(ctl[2]), .i_tx(peer_tx), .o_miso(peer_miso), .o_rx(peer_rx));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
  task check(input string what, input [7:0] seen, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task pulse_wr(input [7:0] b);
    @(posedge clk) begin wr <= 1; wdata <= b; end
    @(posedge clk) wr <= 0;
  endtask
  task pulse_rd;
    @(posedge clk) rd <= 1;
    @(posedge clk) rd <= 0;
  endtask
  // Bench as master, phases of four and five cycles
  task sbits(input [7:0] tx, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) begin
      @(posedge clk) mosi_drv <= tx[7 - k];
      repeat (4) @(posedge clk);
      got = {got[6:0], miso};
      sck_drv <= 1;
      repeat (4) @(posedge clk);
      sck_drv <= 0;
    end
  endtask
  task t_slave;
    @(posedge clk) ctl <= 8'h40;
    sbits(8'h00, 8);
    check("miso_oe idle", miso_oe, 0);
    ss_n <= 0;
    sbits(8'hff, 3);
    ss_n <= 1;
    pulse_wr(8'h96);
    sbits(8'h00, 8);
    ss_n <= 0;
    sbits(8'h5a, 8);
    repeat (8) @(posedge clk);
    check("slave tx", got, 8'h96);
    check("slave rx", rdata, 8'h5a);
    check("slave done", done, 1);
    check("slave oe", {mosi_oe, sck_oe, miso_oe}, 8'h01);
    ss_n <= 1;
    pulse_rd;
    $display("test slave done");
  endtask
  task mxfer(input [7:0] c, input d, input [7:0] tx, input cl);
    integer k, cnt, w0, half;
    half = (c[1:0] == 0 ? 2 : c[1:0] == 1 ? 8 : c[1:0] == 2 ? 32 : 64) >> d;
    w0 = wakes;
    cnt = 0;
    @(posedge clk) begin ctl <= c; dbl <= d; peer_tx <= ~tx; end
    // Idle clock settles at the new polarity before select falls
    repeat (3) @(posedge clk);
    ss_n <= 0;
    pulse_wr(tx);
    if (cl) begin repeat (3) @(posedge clk); pulse_wr(8'hff); end
    for (k = 0; k < 3000 && done !== 1'b1; k = k + 1) begin
      @(posedge clk);
      if (busy === 1'b1) cnt = cnt + 1;
    end
    check("busy span", cnt >= 16*half - 2 - 5*cl && cnt <= 16*half + 2, 1);
    repeat (2) @(posedge clk);
    check("peer rx", peer_rx, tx);
    check("rx buffer", rdata, ~tx);
    check("irq", irq, c[7]);
    check("collision", coll, cl);
    check("master oe", {mosi_oe, sck_oe, miso_oe}, 8'h06);
    check("wake", wakes - w0, 1);
    ss_n <= 1;
    pulse_rd;
    repeat (2) @(posedge clk);
    check("done cleared", done, 0);
    $display("test master %h done", tx);
  endtask
  task t_gate;
    @(posedge clk) gate <= 1;
    pulse_wr(8'h55);
    repeat (20) @(posedge clk);
    check("gated busy", {busy, done}, 0);
    gate <= 0;
    $display("test gate done");
  endtask
  task t_fault;
    @(posedge clk) ctl <= 8'h48;
    @(posedge clk) begin ctl <= 8'h58; ssin <= 1; end
    repeat (6) @(posedge clk);
    check("master on", mst, 1);
    ss_n <= 0;
    repeat (6) @(posedge clk);
    check("fault state", {mst, done}, 8'h01);
    ss_n <= 1;
    $display("test fault done");
  endtask
  task close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    check("reset outs", {busy, done, coll, mst, miso_oe, mosi_oe, sck_oe, irq}, 8'h00);
    check("reset rdata", rdata, 8'h00);
    t_slave;
    for (i = 0; i < 8; i = i + 1)
      mxfer({i[0], 1'b1, i[0] ^ i[2], 5'b10000} | i[1:0], i[2], 8'ha5 ^ i[7:0], 1'b0);
    mxfer(8'hdc, 1'b0, 8'h3c, 1'b0);
    mxfer(8'h74, 1'b1, 8'hc3, 1'b0);
    mxfer(8'hd8, 1'b0, 8'h69, 1'b0);
    mxfer(8'hd0, 1'b0, 8'h81, 1'b1);
    t_gate;
    t_fault;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors = num_errors + 1;
    close_out;
  end
endmodule
